// file: design/cmt_pkg.sv
// Package: register map, field layout, geometry and shared types of the cache/TCM block
package cmt_pkg;
  // ----------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] OFF_CFG = 8'h04;
  localparam logic [7:0] OFF_CTRL = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;
  localparam logic [7:0] OFF_MAINT0 = 8'h20;
  localparam logic [7:0] OFF_MAINT1 = 8'h24;
  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int CFG_SIZE_LSB = 0;
  localparam int CTRL_EN_BIT = 0;
  localparam int STATUS_EN_BIT = 0;
  localparam int INVALIDATE_ALL_TRIGGER_BIT = 0;
  localparam int MAINT_LINE_SET_INDEX_LSB = 4;
  localparam int MAINT_LINE_WAY_SELECT_LSB = 28;
  localparam logic [1:0] CFG_SIZE_RST = 2'h3;
  localparam logic CTRL_EN_RST = 1'b0;
  // ----------------------------------------
  // Cache size codes
  // ----------------------------------------
  localparam logic [1:0] SIZE_0KB = 2'h0;
  localparam logic [1:0] SIZE_1KB = 2'h1;
  localparam logic [1:0] SIZE_2KB = 2'h2;
  localparam logic [1:0] SIZE_4KB = 2'h3;
  // ----------------------------------------
  // Geometry
  // ----------------------------------------
  localparam int MAX_WAYS = 4;
  localparam int WAY_W = 2;
  localparam int WAY_BYTES = 1024;
  localparam int WAY_OFF_W = 10;
  localparam int LINE_BYTES = 16;
  localparam int LINE_W = 4;
  localparam int SETS = WAY_BYTES / LINE_BYTES;
  localparam int IDX_W = 6;
  localparam int TAG_W = 32 - WAY_OFF_W;
  localparam int RAM_W = 12;
  localparam int BYTES_W = 13;
  localparam logic [12:0] MAX_CACHE_BYTES = 13'h1000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [2:0] {
    CMT_RUN = 3'b001,
    CMT_OFF = 3'b010,
    CMT_CLR = 3'b100
  } cmt_state_t;

  typedef struct packed {
    logic wr;
    logic [7:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic rd;
    logic [7:0] raddr;
  } cmt_reg_req_t;

  typedef struct packed {
    logic werr;
    logic [31:0] rdata;
    logic rerr;
  } cmt_reg_rsp_t;
endpackage

// file: design/cmt_axil_slave.sv
// AXI4-Lite slave front end turning bus transfers into register strobes
`timescale 1ns/1ps
`default_nettype none
module cmt_axil_slave (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write address and data
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // Write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // Read
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Register side
  output cmt_pkg::cmt_reg_req_t req,
  input wire cmt_pkg::cmt_reg_rsp_t rsp
);
  logic aw_full, w_full;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic next_aw_full, next_w_full, next_bvalid, next_rvalid;
  logic [7:0] next_aw_addr;
  logic [31:0] next_w_data, next_rdata;
  logic [3:0] next_w_strb;
  logic [1:0] next_bresp, next_rresp;

  // Address and data are latched separately, so either may come first
  assign awready = !aw_full;
  assign wready = !w_full;
  assign arready = !rvalid;

  always_comb begin
    req.wr = aw_full && w_full && !bvalid;
    req.waddr = aw_addr;
    req.wdata = w_data;
    req.wstrb = w_strb;
    req.rd = arvalid && !rvalid;
    req.raddr = araddr;
  end

  always_comb begin
    next_aw_full = aw_full;
    next_w_full = w_full;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (awvalid && awready) begin
      next_aw_full = 1'b1;
      next_aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      next_w_full = 1'b1;
      next_w_data = wdata;
      next_w_strb = wstrb;
    end
    if (req.wr) begin
      next_aw_full = 1'b0;
      next_w_full = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = rsp.werr ? cmt_pkg::RESP_SLVERR : cmt_pkg::RESP_OKAY;
    end else if (bvalid && bready) begin
      next_bvalid = 1'b0;
    end
    if (req.rd) begin
      next_rvalid = 1'b1;
      next_rdata = rsp.rdata;
      next_rresp = rsp.rerr ? cmt_pkg::RESP_SLVERR : cmt_pkg::RESP_OKAY;
    end else if (rvalid && rready) begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= 2'h0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= 2'h0;
    end else begin
      aw_full <= next_aw_full;
      w_full <= next_w_full;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end
endmodule
`default_nettype wire

// file: design/cmt_way_bank.sv
// One cache way: per-set valid bit and tag held in flip-flops
`timescale 1ns/1ps
`default_nettype none
module cmt_way_bank #(
  parameter int SETS = cmt_pkg::SETS,
  parameter int IDX_W = cmt_pkg::IDX_W,
  parameter int TAG_W = cmt_pkg::TAG_W
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Invalidate one set
  input wire logic clr_en,
  input wire logic [IDX_W-1:0] clr_idx,
  // Refill one set
  input wire logic fill_en,
  input wire logic [IDX_W-1:0] fill_idx,
  input wire logic [TAG_W-1:0] fill_tag,
  // Lookup
  input wire logic [IDX_W-1:0] look_idx,
  output logic look_valid,
  output logic [TAG_W-1:0] look_tag,
  output logic [SETS-1:0] valid_vec
);
  logic [SETS-1:0] valid, next_valid;
  logic [TAG_W-1:0] tag [SETS];
  logic [TAG_W-1:0] next_tag [SETS];

  assign look_valid = valid[look_idx];
  assign look_tag = tag[look_idx];
  assign valid_vec = valid;

  // Clear wins over fill; the controller never asks both at once
  always_comb begin
    next_valid = valid;
    next_tag = tag;
    if (fill_en) begin
      next_valid[fill_idx] = 1'b1;
      next_tag[fill_idx] = fill_tag;
    end
    if (clr_en) begin
      next_valid[clr_idx] = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      valid <= '0;
    end else begin
      valid <= next_valid;
    end
  end

  // Tags need no reset: a tag is only read beside its valid bit
  always_ff @(posedge aclk) begin
    tag <= next_tag;
  end
endmodule
`default_nettype wire

// file: design/cmt_cache_tcm.sv
// Cache/TCM split controller with line and full invalidate maintenance
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Cache size follows software select: 4, 2, 1 or 0 KB.
// - TCM size equals 4 KB minus the configured cache size.
// - Cache occupies the low RAM addresses, TCM sits directly above.
// - Ways are 1 KB each; active way count follows the cache size.
// - While the controller is off, the whole 4 KB acts as TCM.
// - TCM accesses work at once, with no locking step.
// - Line invalidate, issued while off, clears the valid bit of the given set and way.
// - After a line invalidate the replacement pointer aims at that way.
// - A status bit shows when the controller has really turned off.
// - Invalidate-all, issued while off, clears every valid bit before re-enable.
module cmt_cache_tcm #(
  parameter int SETS = cmt_pkg::SETS
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite register bus
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Cacheable fetch lookup
  input wire logic fetch_req,
  input wire logic [31:0] fetch_addr,
  output logic fetch_done,
  output logic fetch_hit,
  output logic [11:0] fetch_ram_addr,
  // Line refill after a miss
  input wire logic refill_req,
  input wire logic [31:0] refill_addr,
  input wire logic refill_pending,
  // Direct TCM access
  input wire logic tcm_req,
  input wire logic [11:0] tcm_offset,
  output logic tcm_done,
  output logic tcm_err,
  output logic [11:0] tcm_ram_addr,
  // Current split
  output logic [12:0] cache_bytes,
  output logic [12:0] tcm_bytes
);
  localparam int IW = cmt_pkg::IDX_W;
  localparam int TW = cmt_pkg::TAG_W;
  localparam int NW = cmt_pkg::MAX_WAYS;

  // ----------------------------------------
  // Register bus
  // ----------------------------------------
  cmt_pkg::cmt_reg_req_t req;
  cmt_pkg::cmt_reg_rsp_t rsp;

  cmt_axil_slave u_bus (
    .aclk(aclk),
    .aresetn(aresetn),
    .awvalid(awvalid),
    .awready(awready),
    .awaddr(awaddr),
    .wvalid(wvalid),
    .wready(wready),
    .wdata(wdata),
    .wstrb(wstrb),
    .bvalid(bvalid),
    .bready(bready),
    .bresp(bresp),
    .arvalid(arvalid),
    .arready(arready),
    .araddr(araddr),
    .rvalid(rvalid),
    .rready(rready),
    .rdata(rdata),
    .rresp(rresp),
    .req(req),
    .rsp(rsp)
  );

  cmt_pkg::cmt_state_t state, next_state;
  logic [1:0] cache_size_select, next_size;
  logic cache_ctrl_enable, next_en;
  logic [IW-1:0] clr_cnt, next_clr_cnt;
  logic [31:0] wmask, wval;
  logic [32:0] cur_wr;
  logic cache_enabled_status, invalidate_all_trigger;
  logic invall_go, line_go;
  logic [IW-1:0] maint_line_set_index;
  logic [cmt_pkg::WAY_W-1:0] maint_line_way_select;

  assign cache_enabled_status = (state == cmt_pkg::CMT_RUN);
  assign invalidate_all_trigger = (state == cmt_pkg::CMT_CLR);
  assign wmask = {{8{req.wstrb[3]}}, {8{req.wstrb[2]}}, {8{req.wstrb[1]}}, {8{req.wstrb[0]}}};

  // Readback for either port's address
  function automatic logic [32:0] reg_read(input logic [7:0] a, input logic [1:0] sz,
                                           input logic en, input logic st, input logic ia);
    logic [32:0] r;
    r = '0;
    unique case (a)
      cmt_pkg::OFF_CFG: r[cmt_pkg::CFG_SIZE_LSB +: 2] = sz;
      cmt_pkg::OFF_CTRL: r[cmt_pkg::CTRL_EN_BIT] = en;
      cmt_pkg::OFF_STATUS: r[cmt_pkg::STATUS_EN_BIT] = st;
      cmt_pkg::OFF_MAINT0: r[cmt_pkg::INVALIDATE_ALL_TRIGGER_BIT] = ia;
      cmt_pkg::OFF_MAINT1: r = '0;
      default: r[32] = 1'b1;
    endcase
    return r;
  endfunction

  always_comb begin
    logic [32:0] rr;
    rr = reg_read(req.raddr, cache_size_select, cache_ctrl_enable,
                  cache_enabled_status, invalidate_all_trigger);
    rsp.rdata = rr[31:0];
    rsp.rerr = rr[32];
    cur_wr = reg_read(req.waddr, cache_size_select, cache_ctrl_enable,
                      cache_enabled_status, invalidate_all_trigger);
    rsp.werr = cur_wr[32];
    wval = (cur_wr[31:0] & ~wmask) | (req.wdata & wmask);
  end

  // Maintenance is taken only once the controller is off
  assign invall_go = req.wr && req.waddr == cmt_pkg::OFF_MAINT0 &&
                     wval[cmt_pkg::INVALIDATE_ALL_TRIGGER_BIT] && state == cmt_pkg::CMT_OFF;
  assign line_go = req.wr && req.waddr == cmt_pkg::OFF_MAINT1 &&
                   state == cmt_pkg::CMT_OFF;
  assign maint_line_set_index = wval[cmt_pkg::MAINT_LINE_SET_INDEX_LSB +: IW];
  assign maint_line_way_select = wval[cmt_pkg::MAINT_LINE_WAY_SELECT_LSB +: cmt_pkg::WAY_W];

  // ----------------------------------------
  // Control state
  // ----------------------------------------
  always_comb begin
    next_state = state;
    next_clr_cnt = clr_cnt;
    next_size = cache_size_select;
    next_en = cache_ctrl_enable;
    if (req.wr && req.waddr == cmt_pkg::OFF_CFG) begin
      next_size = wval[cmt_pkg::CFG_SIZE_LSB +: 2];
    end
    if (req.wr && req.waddr == cmt_pkg::OFF_CTRL) begin
      next_en = wval[cmt_pkg::CTRL_EN_BIT];
    end
    unique case (state)
      cmt_pkg::CMT_RUN: begin
        if (!cache_ctrl_enable && !refill_pending) begin
          next_state = cmt_pkg::CMT_OFF;
        end
      end
      cmt_pkg::CMT_OFF: begin
        if (invall_go) begin
          next_state = cmt_pkg::CMT_CLR;
          next_clr_cnt = '0;
        end else if (cache_ctrl_enable) begin
          next_state = cmt_pkg::CMT_RUN;
        end
      end
      cmt_pkg::CMT_CLR: begin
        next_clr_cnt = IW'(clr_cnt + 1'b1);
        if (clr_cnt == IW'(SETS - 1)) begin
          next_state = cache_ctrl_enable ? cmt_pkg::CMT_RUN : cmt_pkg::CMT_OFF;
        end
      end
      default: next_state = cmt_pkg::CMT_OFF;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= cmt_pkg::CMT_OFF;
      clr_cnt <= '0;
      cache_size_select <= cmt_pkg::CFG_SIZE_RST;
      cache_ctrl_enable <= cmt_pkg::CTRL_EN_RST;
    end else begin
      state <= next_state;
      clr_cnt <= next_clr_cnt;
      cache_size_select <= next_size;
      cache_ctrl_enable <= next_en;
    end
  end

  // ----------------------------------------
  // Split of the shared RAM
  // ----------------------------------------
  logic [2:0] cfg_ways, n_ways;

  always_comb begin
    unique case (cache_size_select)
      cmt_pkg::SIZE_0KB: cfg_ways = 3'h0;
      cmt_pkg::SIZE_1KB: cfg_ways = 3'h1;
      cmt_pkg::SIZE_2KB: cfg_ways = 3'h2;
      cmt_pkg::SIZE_4KB: cfg_ways = 3'h4;
    endcase
  end
  assign n_ways = cache_enabled_status ? cfg_ways : 3'h0;
  assign cache_bytes = {n_ways, {cmt_pkg::WAY_OFF_W{1'b0}}};
  assign tcm_bytes = cmt_pkg::MAX_CACHE_BYTES - cache_bytes;

  // ----------------------------------------
  // Ways, lookup and replacement
  // ----------------------------------------
  logic [NW-1:0] look_valid;
  logic [TW-1:0] look_tag [NW];
  logic [SETS-1:0] valid_vec [NW];
  logic [cmt_pkg::WAY_W-1:0] repl_way, next_repl, hit_way;
  logic hit_any, fill_go;

  assign fill_go = refill_req && cache_enabled_status && n_ways != 3'h0;

  for (genvar g = 0; g < NW; g++) begin : g_way
    cmt_way_bank #(.SETS(SETS), .IDX_W(IW), .TAG_W(TW)) u_way (
      .aclk(aclk),
      .aresetn(aresetn),
      .clr_en(invalidate_all_trigger || (line_go && maint_line_way_select == g)),
      .clr_idx(invalidate_all_trigger ? clr_cnt : maint_line_set_index),
      .fill_en(fill_go && repl_way == g),
      .fill_idx(refill_addr[cmt_pkg::LINE_W +: IW]),
      .fill_tag(refill_addr[31 -: TW]),
      .look_idx(fetch_addr[cmt_pkg::LINE_W +: IW]),
      .look_valid(look_valid[g]),
      .look_tag(look_tag[g]),
      .valid_vec(valid_vec[g])
    );
  end

  always_comb begin
    hit_any = 1'b0;
    hit_way = '0;
    for (int i = 0; i < NW; i++) begin
      if (!hit_any && look_valid[i] && look_tag[i] == fetch_addr[31 -: TW] &&
          3'(i) < n_ways) begin
        hit_any = 1'b1;
        hit_way = cmt_pkg::WAY_W'(i);
      end
    end
  end

  logic next_fetch_done, next_fetch_hit, next_tcm_done, next_tcm_err;
  logic [11:0] next_fetch_ram_addr, next_tcm_ram_addr;

  always_comb begin
    next_repl = repl_way;
    if (line_go) begin
      next_repl = maint_line_way_select;
    end else if (fill_go) begin
      next_repl = (3'(repl_way) + 3'h1 >= n_ways) ? '0 : cmt_pkg::WAY_W'(repl_way + 1'b1);
    end else if (cache_enabled_status && 3'(repl_way) >= n_ways) begin
      next_repl = '0;
    end
    next_fetch_done = fetch_req;
    next_fetch_hit = fetch_req && cache_enabled_status && hit_any;
    // way g lives at g KB
    next_fetch_ram_addr = {hit_way, fetch_addr[cmt_pkg::WAY_OFF_W-1:0]};
    next_tcm_done = tcm_req;
    next_tcm_err = tcm_req && ({1'b0, tcm_offset} >= tcm_bytes);
    next_tcm_ram_addr = 12'(cache_bytes + {1'b0, tcm_offset});
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      repl_way <= '0;
      fetch_done <= 1'b0;
      fetch_hit <= 1'b0;
      fetch_ram_addr <= 12'h000;
      tcm_done <= 1'b0;
      tcm_err <= 1'b0;
      tcm_ram_addr <= 12'h000;
    end else begin
      repl_way <= next_repl;
      fetch_done <= next_fetch_done;
      fetch_hit <= next_fetch_hit;
      fetch_ram_addr <= next_fetch_ram_addr;
      tcm_done <= next_tcm_done;
      tcm_err <= next_tcm_err;
      tcm_ram_addr <= next_tcm_ram_addr;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_size_map;
    @(posedge aclk) disable iff (!aresetn)
      cache_enabled_status && cache_size_select == cmt_pkg::SIZE_2KB |-> cache_bytes == 13'h0800;
  endproperty
  a_size_map: assert property (p_size_map) else $error("cache size wrong");
  property p_split_sum;
    @(posedge aclk) disable iff (!aresetn) cache_bytes + tcm_bytes == cmt_pkg::MAX_CACHE_BYTES;
  endproperty
  a_split_sum: assert property (p_split_sum) else $error("split sum wrong");
  property p_tcm_place;
    @(posedge aclk) disable iff (!aresetn)
      tcm_req ##1 !$changed(cache_bytes) |-> tcm_ram_addr == 12'(cache_bytes + $past(tcm_offset));
  endproperty
  a_tcm_place: assert property (p_tcm_place) else $error("TCM address wrong");
  property p_ways_bytes;
    @(posedge aclk) disable iff (!aresetn)
      cache_enabled_status |-> cache_bytes == 13'(cfg_ways) * 13'h0400;
  endproperty
  a_ways_bytes: assert property (p_ways_bytes) else $error("way count wrong");
  property p_off_full;
    @(posedge aclk) disable iff (!aresetn) !cache_enabled_status |-> tcm_bytes == 13'h1000;
  endproperty
  a_off_full: assert property (p_off_full) else $error("TCM not full");
  property p_tcm_answer;
    @(posedge aclk) disable iff (!aresetn) tcm_req |=> tcm_done;
  endproperty
  a_tcm_answer: assert property (p_tcm_answer) else $error("TCM not answered");
  property p_line_clear;
    @(posedge aclk) disable iff (!aresetn)
      line_go |=> !valid_vec[$past(maint_line_way_select)][$past(maint_line_set_index)];
  endproperty
  a_line_clear: assert property (p_line_clear) else $error("line still valid");
  property p_repl_point;
    @(posedge aclk) disable iff (!aresetn) line_go |=> repl_way == $past(maint_line_way_select);
  endproperty
  a_repl_point: assert property (p_repl_point) else $error("pointer wrong");
  property p_status_off;
    @(posedge aclk) disable iff (!aresetn)
      cache_enabled_status && !cache_ctrl_enable && !refill_pending |=> !cache_enabled_status;
  endproperty
  a_status_off: assert property (p_status_off) else $error("status not off");
  property p_clear_all;
    @(posedge aclk) disable iff (!aresetn)
      invalidate_all_trigger && clr_cnt == IW'(SETS - 1) |=>
        valid_vec[0] == '0 && valid_vec[1] == '0 && valid_vec[2] == '0 && valid_vec[3] == '0;
  endproperty
  a_clear_all: assert property (p_clear_all) else $error("clear all incomplete");
  property p_self_clear;
    @(posedge aclk) disable iff (!aresetn)
      $fell(invalidate_all_trigger) |-> ##[0:1] rsp.rdata == '0 || req.raddr != cmt_pkg::OFF_MAINT0;
  endproperty
  a_self_clear: assert property (p_self_clear) else $error("trigger stuck");
  c_hit: cover property (@(posedge aclk) disable iff (!aresetn) fetch_hit);
  c_line: cover property (@(posedge aclk) disable iff (!aresetn) line_go);
  c_all: cover property (@(posedge aclk) disable iff (!aresetn) $fell(invalidate_all_trigger));
  c_tcm_err: cover property (@(posedge aclk) disable iff (!aresetn) tcm_err);
endmodule
`default_nettype wire

// file: verification/cmt_core_model.sv
// Core-side model: issues fetch, refill and TCM requests on command
`timescale 1ns/1ps
`default_nettype none
module cmt_core_model (
  // Clock
  input wire logic aclk,
  // Bench commands: 1 fetch, 2 refill, 3 TCM access
  input wire logic [1:0] go,
  input wire logic [31:0] addr,
  // Core requests
  output logic fetch_req = 1'b0,
  output logic refill_req = 1'b0,
  output logic refill_pending = 1'b0,
  output logic tcm_req = 1'b0,
  output logic [31:0] req_addr = 32'h0
);
  int pend = 0;
  always @(posedge aclk) begin
    fetch_req <= go == 2'h1;
    refill_req <= go == 2'h2;
    tcm_req <= go == 2'h3;
    // Idle address lines toggle so stale values never look valid
    req_addr <= (go != 2'h0) ? addr : ~req_addr;
    // A refill stays in flight a few cycles, as a slow bus would
    pend <= (go == 2'h2) ? 4 : ((pend > 0) ? pend - 1 : 0);
    refill_pending <= (go == 2'h2) || (pend > 1);
  end
endmodule
`default_nettype wire

// file: verification/cmt_cache_tcm_test.sv
// Testbench: split, TCM access and maintenance against a bench model
`timescale 1ns/1ps
`default_nettype none
module cmt_cache_tcm_test;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, addr = 0, qa, a, d;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, fetch_done, fetch_hit, tcm_done, tcm_err;
  logic fq, rq, rp, tq;
  logic [1:0] bresp, rresp, go = 0, r, w;
  logic [11:0] fetch_ram_addr, tcm_ram_addr;
  logic [12:0] cache_bytes, tcm_bytes;
  int bad_count = 0, cmp_count = 0, cb, off, n;
  initial forever #12.5 aclk = ~aclk;
  cmt_cache_tcm dut_u (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .fetch_req(fq), .fetch_addr(qa), .fetch_done(fetch_done), .fetch_hit(fetch_hit),
    .fetch_ram_addr(fetch_ram_addr), .refill_req(rq), .refill_addr(qa), .refill_pending(rp),
    .tcm_req(tq), .tcm_offset(qa[11:0]), .tcm_done(tcm_done), .tcm_err(tcm_err),
    .tcm_ram_addr(tcm_ram_addr), .cache_bytes(cache_bytes), .tcm_bytes(tcm_bytes));
  cmt_core_model core_u (.aclk(aclk), .go(go), .addr(addr), .fetch_req(fq), .refill_req(rq),
    .refill_pending(rp), .tcm_req(tq), .req_addr(qa));
  task automatic close_out();
    $display("checks %0d errors %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, s, e);
    end
  endtask
  // Ready is sampled at the falling edge, where it holds until the next rise
  task automatic wr(input logic [7:0] ad, input logic [31:0] dt, output logic [1:0] rs);
    logic ah, wh, bh;
    @(posedge aclk);
    awvalid <= 1; awaddr <= ad; wvalid <= 1; wdata <= dt; bready <= 1;
    bh = 0;
    for (int i = 0; i < 50 && !bh; i++) begin
      @(negedge aclk);
      ah = awvalid && awready; wh = wvalid && wready; bh = bvalid; rs = bresp;
      @(posedge aclk);
      if (ah) awvalid <= 0;
      if (wh) wvalid <= 0;
      if (bh) bready <= 0;
    end
  endtask
  task automatic rd(input logic [7:0] ad, output logic [31:0] dt, output logic [1:0] rs);
    logic ah, rh;
    @(posedge aclk);
    arvalid <= 1; araddr <= ad; rready <= 1;
    rh = 0;
    for (int i = 0; i < 50 && !rh; i++) begin
      @(negedge aclk);
      ah = arvalid && arready; rh = rvalid; dt = rdata; rs = rresp;
      @(posedge aclk);
      if (ah) arvalid <= 0;
      if (rh) rready <= 0;
    end
  endtask
  task automatic op(input logic [1:0] k, input logic [31:0] ad);
    @(posedge aclk); go <= k; addr <= ad;
    @(posedge aclk); go <= 0;
    @(posedge aclk);
    @(negedge aclk);
  endtask
  task automatic wstat(input logic v);
    n = 0;
    do begin rd(cmt_pkg::OFF_STATUS, d, r); n++; end while (d[0] !== v && n < 50);
    chk(d[0], v);
  endtask
  task automatic en(input logic v);
    wr(cmt_pkg::OFF_CTRL, {31'h0, v}, r);
    wstat(v);
  endtask
  initial begin
    #(25 * 40000);
    bad_count++;
    close_out();
  end
  initial begin
    void'($urandom(78));
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    rd(cmt_pkg::OFF_CFG, d, r);
    chk(d[1:0], cmt_pkg::SIZE_4KB);
    chk(tcm_bytes, 13'h1000);
    for (int s = 0; s < 4; s++) begin
      wr(cmt_pkg::OFF_CFG, s, r);
      en(1);
      cb = (s == 3) ? 4096 : s * 1024;
      chk(cache_bytes, cb);
      chk(tcm_bytes, 4096 - cb);
      off = $urandom_range(4095, 0);
      op(2'h3, off);
      chk(tcm_done, 1);
      chk(tcm_err, off >= 4096 - cb);
      if (off < 4096 - cb) chk(tcm_ram_addr, (cb + off) % 4096);
      en(0);
      chk(cache_bytes, 0);
    end
    a = $urandom;
    w = $urandom_range(3, 0);
    wr(cmt_pkg::OFF_MAINT1, {2'h0, w, 18'h0, a[9:4], 4'h0}, r);
    chk(r, cmt_pkg::RESP_OKAY);
    en(1);
    op(2'h2, a);
    op(2'h1, a);
    chk(fetch_hit, 1);
    chk(fetch_done, 1);
    chk(fetch_ram_addr, {w, a[9:0]});
    en(0);
    wr(cmt_pkg::OFF_MAINT1, {2'h0, w, 18'h0, a[9:4], 4'h0}, r);
    en(1);
    op(2'h1, a);
    chk(fetch_hit, 0);
    op(2'h2, a);
    op(2'h1, a);
    chk(fetch_hit, 1);
    en(0);
    wr(cmt_pkg::OFF_MAINT0, 32'h1, r);
    rd(cmt_pkg::OFF_MAINT0, d, r);
    chk(d[0], 1);
    n = 0;
    do begin rd(cmt_pkg::OFF_MAINT0, d, r); n++; end while (d[0] !== 0 && n < 100);
    chk(d[0], 0);
    en(1);
    op(2'h1, a);
    chk(fetch_hit, 0);
    rd(8'h10, d, r);
    chk(r, cmt_pkg::RESP_SLVERR);
    wr(8'h10, 32'h1, r);
    chk(r, cmt_pkg::RESP_SLVERR);
    close_out();
  end
endmodule
`default_nettype wire
